// *** core/php_port.sv ***
// parallel handshake port: pin logic and AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module php_port (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [3:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [3:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire php_pkg::php_pins_in_t  pins_in,
  output php_pkg::php_pins_out_t      pins_out
);
  import php_pkg::*;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  php_pins_in_t meta_q;
  php_pins_in_t sync_q;
  php_pins_in_t prev_q;

  // stage one is read by stage two only
  always_ff @(posedge aclk) begin
    meta_q <= pins_in;
    sync_q <= meta_q;
    prev_q <= sync_q;
  end

  logic in_tgl;
  logic in_tgl_prev;
  logic out_tgl;
  logic out_tgl_prev;
  logic lo_rise;
  logic hi_rise;
  logic in_tgl_rise;
  logic out_tgl_rise;
  logic start_rise;

  assign in_tgl       = ~(sync_q.input_toggle_enable & sync_q.input_toggle_strobe);
  assign in_tgl_prev  = ~(prev_q.input_toggle_enable & prev_q.input_toggle_strobe);
  assign out_tgl      = ~(sync_q.output_toggle_enable & sync_q.output_clear_strobe);
  assign out_tgl_prev = ~(prev_q.output_toggle_enable & prev_q.output_clear_strobe);
  assign in_tgl_rise  = in_tgl & ~in_tgl_prev & aresetn;
  assign out_tgl_rise = out_tgl & ~out_tgl_prev & aresetn;
  assign lo_rise      = sync_q.low_byte_latch_strobe & ~prev_q.low_byte_latch_strobe & aresetn;
  assign hi_rise      = sync_q.high_byte_latch_strobe & ~prev_q.high_byte_latch_strobe & aresetn;
  assign start_rise   = sync_q.process_start_n & ~prev_q.process_start_n & aresetn;

  // ---------------------------------------------------------------
  // register bus decode
  // ---------------------------------------------------------------
  logic        aw_held_q;
  logic [3:0]  aw_addr_q;
  logic        w_held_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_go;
  logic        wr_ctrl;
  logic        wr_tx;
  logic        rd_go;
  logic        rd_rx;

  assign wr_go   = aw_held_q & w_held_q & ~s_axi_bvalid;
  assign wr_ctrl = wr_go & (aw_addr_q == REG_CTRL);
  assign wr_tx   = wr_go & (aw_addr_q == REG_TXDATA);
  assign rd_go   = s_axi_arvalid & s_axi_arready;
  assign rd_rx   = rd_go & (s_axi_araddr == REG_RXDATA);

  // ---------------------------------------------------------------
  // input side
  // ---------------------------------------------------------------
  logic             mode16_q;
  logic [7:0]       lo_latch_q;
  logic [7:0]       hi_latch_q;
  logic [15:0]      rx_data_q;
  logic             rx_valid_q;
  logic             busy_q;
  logic [LAT_W-1:0] lat_cnt_q;
  logic             input_ready_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lo_latch_q <= 8'h00;
      hi_latch_q <= 8'h00;
    end else begin
      if (lo_rise) begin
        lo_latch_q <= sync_q.low_input_byte;
      end
      if (hi_rise && mode16_q) begin
        hi_latch_q <= sync_q.high_input_byte;
      end
    end
  end

  // a start edge hands the latches to software; a read clears the flag unless a new start lands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_data_q  <= 16'h0000;
      rx_valid_q <= 1'b0;
    end else if (start_rise) begin
      rx_data_q  <= {mode16_q ? hi_latch_q : 8'h00, lo_latch_q};
      rx_valid_q <= 1'b1;
    end else if (rd_rx) begin
      rx_valid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q    <= 1'b0;
      lat_cnt_q <= '0;
    end else if (start_rise) begin
      busy_q    <= 1'b1;
      lat_cnt_q <= mode16_q ? LAT_W'(IN_LAT16_CYC - 1) : LAT_W'(IN_LAT8_CYC - 1);
    end else if (busy_q) begin
      if (lat_cnt_q == '0) begin
        busy_q <= 1'b0;
      end else begin
        lat_cnt_q <= lat_cnt_q - LAT_W'(1);
      end
    end
  end

  // the toggle edge wins over software enabling in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_ready_q <= 1'b0;
    end else if (in_tgl_rise) begin
      input_ready_q <= 1'b0;
    end else if (busy_q && lat_cnt_q == '0) begin
      input_ready_q <= 1'b1;
    end else if (wr_ctrl && w_strb_q[0] && w_data_q[CTRL_IN_EN]) begin
      input_ready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode16_q <= MODE16_RST;
    end else if (wr_ctrl && w_strb_q[0]) begin
      mode16_q <= w_data_q[CTRL_MODE16];
    end
  end

  // ---------------------------------------------------------------
  // output side
  // ---------------------------------------------------------------
  logic       out_wait_q;
  logic [7:0] lo_out_q;
  logic [7:0] hi_out_q;
  logic       lo_oe_q;
  logic       hi_oe_q;

  // the accept edge wins over a new load in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_wait_q <= 1'b0;
    end else if (out_tgl_rise) begin
      out_wait_q <= 1'b0;
    end else if (wr_tx) begin
      out_wait_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lo_out_q <= 8'h00;
      hi_out_q <= 8'h00;
    end else if (wr_tx) begin
      if (w_strb_q[0]) begin
        lo_out_q <= w_data_q[7:0];
      end
      if (w_strb_q[1]) begin
        hi_out_q <= w_data_q[15:8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lo_oe_q <= 1'b0;
      hi_oe_q <= 1'b0;
    end else begin
      lo_oe_q <= ~sync_q.low_out_drive_en_n;
      hi_oe_q <= ~sync_q.high_out_drive_en_n;
    end
  end

  assign pins_out.input_ready_line    = input_ready_q;
  assign pins_out.output_ready_line   = out_wait_q;
  assign pins_out.low_output_byte     = lo_out_q;
  assign pins_out.high_output_byte    = hi_out_q;
  assign pins_out.low_output_byte_oe  = lo_oe_q;
  assign pins_out.high_output_byte_oe = hi_oe_q;

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_held_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_q <= 1'b0;
      end
    end
  end

  logic awready_q;
  logic wready_q;
  logic arready_q;
  logic bvalid_nx;

  // ready flags are registered copies of what the held and valid flops hold next, so timing is unchanged
  assign bvalid_nx = wr_go | (s_axi_bvalid & ~s_axi_bready);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      arready_q <= 1'b1;
    end else begin
      awready_q <= ~(s_axi_awvalid & s_axi_awready) & ~(aw_held_q & ~wr_go) & ~bvalid_nx;
      wready_q  <= ~(s_axi_wvalid & s_axi_wready) & ~(w_held_q & ~wr_go) & ~bvalid_nx;
      arready_q <= ~rd_go & ~(s_axi_rvalid & ~s_axi_rready);
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr_q == REG_CTRL || aw_addr_q == REG_TXDATA) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign s_axi_arready = arready_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL:   s_axi_rdata <= {31'h0000_0000, mode16_q};
        REG_STATUS: s_axi_rdata <= {28'h000_0000, busy_q, rx_valid_q, out_wait_q, input_ready_q};
        REG_RXDATA: s_axi_rdata <= {16'h0000, rx_data_q};
        REG_TXDATA: s_axi_rdata <= {16'h0000, hi_out_q, lo_out_q};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  localparam int A_LAT8  = IN_LAT8_CYC + 1;
  localparam int A_LAT16 = IN_LAT16_CYC + 1;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_start8;
    start_rise && !mode16_q && !in_tgl_rise;
  endsequence
  sequence s_start16;
    start_rise && mode16_q && !in_tgl_rise;
  endsequence

  a_toggle_clears_ready: assert property (in_tgl_rise |=> !input_ready_q)
    else $error("input toggle did not clear ready");
  a_toggle_from_nand: assert property (in_tgl_rise |->
      $past(sync_q.input_toggle_enable && sync_q.input_toggle_strobe))
    else $error("input toggle rose without both inputs high before");
  a_low_byte_latch: assert property (lo_rise |=> lo_latch_q == $past(sync_q.low_input_byte))
    else $error("low byte not latched");
  a_high_ignored_8bit: assert property (hi_rise && !mode16_q |=> $stable(hi_latch_q))
    else $error("high byte latched in 8-bit mode");
  a_ready_after_8bit: assert property (s_start8 ##1 (!in_tgl_rise [*3]) |->
      ##(A_LAT8 - 3) input_ready_q)
    else $error("8-bit ready latency wrong");
  a_ready_after_16bit: assert property (s_start16 |-> ##A_LAT16 (input_ready_q || $past(in_tgl_rise)))
    else $error("16-bit ready latency wrong");
  a_out_toggle_clears: assert property (out_tgl_rise |=> !pins_out.output_ready_line)
    else $error("output toggle did not clear ready");
  a_tx_sets_ready: assert property (wr_tx && !out_tgl_rise |=> out_wait_q &&
      (!$past(w_strb_q[0]) || lo_out_q == $past(w_data_q[7:0])))
    else $error("output load did not raise ready");
  a_drive_enable: assert property (!sync_q.low_out_drive_en_n ##1 !sync_q.low_out_drive_en_n
      |=> lo_oe_q [*1])
    else $error("low drivers not enabled");
  a_high_release: assert property (sync_q.high_out_drive_en_n |=> !hi_oe_q)
    else $error("high drivers not released");
  a_reset_state: assert property ($past(!aresetn) |-> !input_ready_q && !out_wait_q)
    else $error("indicators not cleared by reset");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");

endmodule
`default_nettype wire

// *** core/php_pkg.sv ***
// constants, layouts and pin bundles of the parallel handshake port
package php_pkg;

  // ---------------------------------------------------------------
  // clock and handshake timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int IN_LAT8_NS    = 500;
  localparam int IN_LAT16_NS   = 920;
  // typical figures, rounded down to whole cycles
  localparam int IN_LAT8_CYC   = (IN_LAT8_NS / CLK_PERIOD_NS) < 1 ? 1 : IN_LAT8_NS / CLK_PERIOD_NS;
  localparam int IN_LAT16_CYC  = (IN_LAT16_NS / CLK_PERIOD_NS) < 1 ? 1 : IN_LAT16_NS / CLK_PERIOD_NS;
  localparam int LAT_W         = 6;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int          ADDR_W      = 4;
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_STATUS  = 4'h4;
  localparam logic [3:0] REG_RXDATA  = 4'h8;
  localparam logic [3:0] REG_TXDATA  = 4'hC;
  // control fields
  localparam int CTRL_MODE16  = 0;
  localparam int CTRL_IN_EN   = 1;
  // status fields
  localparam int ST_IN_READY  = 0;
  localparam int ST_OUT_WAIT  = 1;
  localparam int ST_RX_VALID  = 2;
  localparam int ST_BUSY      = 3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic       MODE16_RST  = 1'h0;

  // ---------------------------------------------------------------
  // pin bundles
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] high_input_byte;
    logic [7:0] low_input_byte;
    logic       low_byte_latch_strobe;
    logic       high_byte_latch_strobe;
    logic       input_toggle_enable;
    logic       input_toggle_strobe;
    logic       process_start_n;
    logic       output_toggle_enable;
    logic       output_clear_strobe;
    logic       low_out_drive_en_n;
    logic       high_out_drive_en_n;
  } php_pins_in_t;

  typedef struct packed {
    logic       input_ready_line;
    logic       output_ready_line;
    logic [7:0] high_output_byte;
    logic [7:0] low_output_byte;
    logic       high_output_byte_oe;
    logic       low_output_byte_oe;
  } php_pins_out_t;

endpackage

// *** sim/php_host_model.sv ***
// behavioural model of the external control device on the port's pins
`timescale 1ns/1ps
`default_nettype none
module php_host_model (
  input  wire logic                   aclk,
  input  wire php_pkg::php_pins_out_t pins_out,
  output var  php_pkg::php_pins_in_t  pins_in,
  output logic [15:0]                 bus_seen
);
  import php_pkg::*;

  logic [15:0] last_q;

  // --------------------------------------------------------------
  // output lines as the device sees them
  // --------------------------------------------------------------
  // a released byte shows the inverse of its last driven value, never a kind copy
  always_ff @(posedge aclk) begin
    if (pins_out.high_output_byte_oe)
      last_q[15:8] <= pins_out.high_output_byte;
    if (pins_out.low_output_byte_oe)
      last_q[7:0] <= pins_out.low_output_byte;
  end
  assign bus_seen[15:8] = pins_out.high_output_byte_oe ? pins_out.high_output_byte : ~last_q[15:8];
  assign bus_seen[7:0]  = pins_out.low_output_byte_oe ? pins_out.low_output_byte : ~last_q[7:0];

  initial begin
    pins_in = '0;
    pins_in.process_start_n = 1'b1;
    pins_in.low_out_drive_en_n = 1'b1;
    pins_in.high_out_drive_en_n = 1'b1;
  end

  task automatic ticks(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // --------------------------------------------------------------
  // input transfer
  // --------------------------------------------------------------
  task automatic push_input(input logic [7:0] hi, input logic [7:0] lo);
    pins_in.high_input_byte <= hi;
    ticks(2);
    pins_in.high_byte_latch_strobe <= 1'b1;
    ticks(4);
    pins_in.high_byte_latch_strobe <= 1'b0;
    pins_in.high_input_byte <= ~hi;
    pins_in.low_input_byte <= lo;
    ticks(2);
    pins_in.low_byte_latch_strobe <= 1'b1;
    ticks(4);
    pins_in.low_byte_latch_strobe <= 1'b0;
    pins_in.low_input_byte <= ~lo;
    pins_in.input_toggle_enable <= 1'b1;
    pins_in.input_toggle_strobe <= 1'b1;
    ticks(4);
    pins_in.input_toggle_strobe <= 1'b0;
    ticks(4);
    pins_in.input_toggle_enable <= 1'b0;
    pins_in.process_start_n <= 1'b0;
    ticks(26);
    pins_in.process_start_n <= 1'b1;
  endtask

  // strobe with the enable low: the toggle must not fire
  task automatic lone_strobe();
    pins_in.input_toggle_strobe <= 1'b1;
    ticks(4);
    pins_in.input_toggle_strobe <= 1'b0;
    ticks(6);
  endtask

  // --------------------------------------------------------------
  // output transfer
  // --------------------------------------------------------------
  task automatic pull_output(input logic m16, output logic [15:0] seen, output logic [1:0] oe);
    pins_in.low_out_drive_en_n <= 1'b0;
    pins_in.high_out_drive_en_n <= ~m16;
    ticks(6);
    seen = bus_seen;
    oe = {pins_out.high_output_byte_oe, pins_out.low_output_byte_oe};
    pins_in.low_out_drive_en_n <= 1'b1;
    pins_in.high_out_drive_en_n <= 1'b1;
    pins_in.output_toggle_enable <= 1'b1;
    pins_in.output_clear_strobe <= 1'b1;
    ticks(4);
    pins_in.output_clear_strobe <= 1'b0;
    ticks(2);
    pins_in.output_toggle_enable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** sim/php_port_tb.sv ***
// self-checking testbench of the parallel handshake port
`timescale 1ns/1ps
`default_nettype none
module php_port_tb;
  import php_pkg::*;

  logic          aclk    = 1'b0;
  logic          aresetn = 1'b0;
  logic [3:0]    awaddr  = 4'h0;
  logic          awvalid = 1'b0;
  logic          awready;
  logic [31:0]   wdata   = 32'h0;
  logic          wvalid  = 1'b0;
  logic          wready;
  logic [1:0]    bresp;
  logic          bvalid;
  logic          bready  = 1'b0;
  logic [3:0]    araddr  = 4'h0;
  logic          arvalid = 1'b0;
  logic          arready;
  logic [31:0]   rdata;
  logic [1:0]    rresp;
  logic          rvalid;
  logic          rready  = 1'b0;
  php_pins_in_t  pins_in;
  php_pins_out_t pins_out;
  logic [15:0]   bus_seen;
  int            n_mismatch   = 0;
  int            total_checks = 0;

  always #(CLK_PERIOD_NS / 2) aclk = ~aclk;

  php_port dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pins_in(pins_in), .pins_out(pins_out)
  );

  php_host_model host (.aclk(aclk), .pins_out(pins_out), .pins_in(pins_in), .bus_seen(bus_seen));

  // --------------------------------------------------------------
  // shared helpers
  // --------------------------------------------------------------
  task automatic ticks(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic check_bit(input string what, input logic seen, input logic exp);
    check(what, {31'h0, seen}, {31'h0, exp});
  endtask

  task automatic report_and_stop();
    if (n_mismatch == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // the watchdog ends any wait for a handshake that never comes
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic read_expect(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] rexp);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    check("rdata", rdata, exp);
    check("rresp", {30'h0, rresp}, {30'h0, rexp});
    @(posedge aclk);
  endtask

  task automatic wait_line(input logic outp, input logic lvl, input int lim, output int n);
    n = 0;
    while ((outp ? pins_out.output_ready_line : pins_out.input_ready_line) !== lvl && n < lim) begin
      @(posedge aclk);
      n++;
    end
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    logic [1:0] r;
    check_bit("in ready", pins_out.input_ready_line, 1'b0);
    check_bit("out ready", pins_out.output_ready_line, 1'b0);
    check("oe", {30'h0, pins_out.high_output_byte_oe, pins_out.low_output_byte_oe}, 32'h0);
    read_expect(REG_CTRL, 32'h0, RESP_OKAY);
    read_expect(REG_STATUS, 32'h0, RESP_OKAY);
    read_expect(4'h6, 32'h0, RESP_SLVERR);
    axi_write(REG_STATUS, 32'h0000_000F, r);
    check("bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    read_expect(REG_STATUS, 32'h0, RESP_OKAY);
  endtask

  task automatic t_input(input logic m16, input logic [7:0] hi, input logic [7:0] lo);
    logic [1:0] r;
    int         n;
    int         lat;
    lat = m16 ? IN_LAT16_CYC + 1 : IN_LAT8_CYC + 1;
    axi_write(REG_CTRL, {30'h0, 1'b1, m16}, r);
    check("bresp", {30'h0, r}, {30'h0, RESP_OKAY});
    ticks(1);
    check_bit("in ready", pins_out.input_ready_line, 1'b1);
    host.lone_strobe();
    check_bit("in ready", pins_out.input_ready_line, 1'b1);
    host.push_input(hi, lo);
    check_bit("in ready", pins_out.input_ready_line, 1'b0);
    wait_line(1'b0, 1'b1, 100, n);
    check_bit("in ready", pins_out.input_ready_line, 1'b1);
    check_bit("latency", n >= lat && n <= lat + 6, 1'b1);
    // in 8-bit mode the high lane was strobed too and must be ignored
    read_expect(REG_STATUS, 32'h5, RESP_OKAY);
    read_expect(REG_RXDATA, {16'h0, m16 ? hi : 8'h00, lo}, RESP_OKAY);
    read_expect(REG_STATUS, 32'h1, RESP_OKAY);
  endtask

  task automatic t_output(input logic m16, input logic [15:0] d);
    logic [1:0]  r;
    logic [1:0]  oe;
    logic [15:0] seen;
    int          n;
    axi_write(REG_CTRL, {31'h0, m16}, r);
    axi_write(REG_TXDATA, {16'h0, d}, r);
    check("bresp", {30'h0, r}, {30'h0, RESP_OKAY});
    ticks(1);
    check_bit("out ready", pins_out.output_ready_line, 1'b1);
    read_expect(REG_STATUS, 32'h3, RESP_OKAY);
    host.pull_output(m16, seen, oe);
    check("oe", {30'h0, oe}, {30'h0, m16, 1'b1});
    check("low byte", {24'h0, seen[7:0]}, {24'h0, d[7:0]});
    if (m16)
      check("high byte", {24'h0, seen[15:8]}, {24'h0, d[15:8]});
    wait_line(1'b1, 1'b0, 20, n);
    check_bit("out ready", pins_out.output_ready_line, 1'b0);
    check("oe", {30'h0, pins_out.high_output_byte_oe, pins_out.low_output_byte_oe}, 32'h0);
  endtask

  // --------------------------------------------------------------
  // main sequence and watchdog
  // --------------------------------------------------------------
  initial begin
    ticks(3);
    aresetn <= 1'b1;
    ticks(1);
    t_reset();
    t_input(1'b0, 8'h5A, 8'hA5);
    t_input(1'b1, 8'h3C, 8'hC3);
    t_output(1'b1, 16'hB47E);
    t_output(1'b0, 16'h0042);
    report_and_stop();
  end

  // the whole run needs well under a thousand cycles
  initial begin
    ticks(5000);
    n_mismatch++;
    report_and_stop();
  end
endmodule
`default_nettype wire
